// ==== hdl/gdc_pkg.sv ====
package gdc_pkg;

  // ==========================================================================
  // widths
  localparam int GDC_NIB_W    = 4;
  localparam int GDC_BYTE_W   = 8;
  localparam int GDC_SEED_W   = 8;
  localparam int GDC_LANES    = 2;
  localparam int GDC_CMD_W    = 3;
  localparam int GDC_BITCNT_W = 3;

  // ==========================================================================
  // sample codes
  localparam logic [3:0] GDC_INVALID_CODE = 4'h5;
  localparam logic [3:0] GDC_FIVE_VALUE   = 4'h5;
  localparam logic [3:0] GDC_FIVE_SUB     = 4'h8;
  localparam logic [3:0] GDC_FILL_NIB     = 4'hA;

  // ==========================================================================
  // chopper generator
  localparam logic [7:0] GDC_PRN_TAPS  = 8'hB8;
  localparam logic [7:0] GDC_SEED_ZERO = 8'h00;
  localparam logic [7:0] GDC_SEED_SAFE = 8'h01;

  // ==========================================================================
  // dump trigger commands
  localparam logic [2:0] GDC_CMD_RECIRC_RESET = 3'h6;

  // ==========================================================================
  // control word bit positions
  localparam int GDC_CB_TIMECODE = 0;
  localparam int GDC_CB_PHASE_MD = 1;
  localparam int GDC_CB_PHASE_ER = 2;
  localparam int GDC_CB_DUMP     = 3;
  localparam int GDC_CB_COMMAND  = 4;
  localparam int GDC_CB_STATUS   = 5;
  localparam int GDC_CB_NPREAMB  = 6;
  localparam int GDC_CB_MARK     = 7;

  localparam logic       GDC_PREAMBLE_IDLE = 1'b0;
  localparam logic [7:0] GDC_IDLE_DATA     = 8'hAA;
  localparam logic [7:0] GDC_IDLE_CTRL     = 8'hC0;
  localparam logic [2:0] GDC_LAST_BIT      = 3'h7;
  localparam int         GDC_FCLK_BIT      = 2;
  localparam int         GDC_SEED_BITS     = 2 * GDC_SEED_W;

endpackage : gdc_pkg

// ==== hdl/gdc_chop.sv ====
`timescale 1ns/1ps
module gdc_chop (
  input  wire logic                           clk_i,     // reference clock
  input  wire logic                           rst_n_i,   // async reset
  input  wire logic                           ce_i,      // clock enable
  input  wire logic                           step_i,    // nibble accepted
  input  wire logic                           phase_i,   // 0 = W0, 1 = W1
  input  wire logic                           preset_i,  // tick marker
  input  wire logic [gdc_pkg::GDC_SEED_W-1:0] seed_i,    // lane seed
  input  wire logic [gdc_pkg::GDC_NIB_W-1:0]  nib_i,     // coded nibble
  output logic      [gdc_pkg::GDC_BYTE_W-1:0] byte_o     // {W1, W0} chopped
);
  import gdc_pkg::*;

  logic [GDC_SEED_W-1:0] prn_q, prn_d, prn_cur;
  logic [GDC_NIB_W-1:0]  w0_q, w0_d, chopped;
  logic [GDC_BYTE_W-1:0] byte_q, byte_d;

  // ==========================================================================
  // generator and chop
  always_comb begin
    prn_cur = preset_i ? seed_i : prn_q;
    chopped = nib_i ^ prn_cur[GDC_NIB_W-1:0];
    prn_d   = prn_q;
    w0_d    = w0_q;
    byte_d  = byte_q;
    if (step_i) begin
      prn_d = {prn_cur[GDC_SEED_W-2:0], ^(prn_cur & GDC_PRN_TAPS)};
      if (!phase_i) begin
        w0_d = chopped;
      end else begin
        byte_d = {chopped, w0_q};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prn_q  <= GDC_SEED_SAFE;
      w0_q   <= '0;
      byte_q <= GDC_IDLE_DATA;
    end else if (ce_i) begin
      prn_q  <= prn_d;
      w0_q   <= w0_d;
      byte_q <= byte_d;
    end
  end

  assign byte_o = byte_q;

endmodule : gdc_chop

// ==== hdl/gdc_tx.sv ====
`timescale 1ns/1ps
module gdc_tx #(
  parameter int WAFER_W  = 4,
  parameter int SOURCE_W = 6,
  parameter int RECIRC_W = 8
) (
  input  wire logic ref_clk_i,                    // reference clock
  input  wire logic reset_n_i,                    // async reset, low
  input  wire logic ce_i,                         // clock enable
  input  wire logic link_clk_i,                   // serial bit clock
  input  wire logic in_valid_i,                   // nibble beat valid
  output logic      in_ready_o,                   // nibble beat taken
  input  wire logic [gdc_pkg::GDC_LANES-1:0]
                    [gdc_pkg::GDC_NIB_W-1:0] sample_nib_i, // samples
  input  wire logic [gdc_pkg::GDC_LANES-1:0] sample_used_i,  // slot used
  input  wire logic [gdc_pkg::GDC_LANES-1:0] sample_valid_i, // sample ok
  input  wire logic tick_i,                       // timecode tick, W0
  input  wire logic timecode_bit_i,               // timecode stream
  input  wire logic phase_model_stream_i,         // phase model bit
  input  wire logic [WAFER_W-1:0] phase_model_wafer_i, // its wafer
  input  wire logic phase_error_stream_i,         // phase error bit
  input  wire logic dump_trigger_stream_i,        // dump trigger bit
  input  wire logic command_bit_i,                // command channel
  input  wire logic status_bit_i,                 // status channel
  input  wire logic [gdc_pkg::GDC_SEED_W-1:0] seed_zero_i, // lane 0 seed
  input  wire logic [gdc_pkg::GDC_SEED_W-1:0] seed_one_i,  // lane 1 seed
  input  wire logic [WAFER_W-1:0]  wafer_id_i,    // own wafer
  input  wire logic [SOURCE_W-1:0] source_identifier_i, // own source
  input  wire logic dump_strobe_i,                // dump frame decoded
  input  wire logic [gdc_pkg::GDC_CMD_W-1:0] dump_cmd_i, // dump command
  input  wire logic [SOURCE_W-1:0] dump_source_i, // frame source id
  input  wire logic block_strobe_i,               // recirc block done
  input  wire logic [RECIRC_W-1:0] start_block_i, // recirc start block
  output logic [RECIRC_W-1:0] recirc_count_o,     // recirc counter
  output logic dump_action_o,                     // dump pulse
  output logic sample_stream_zero_o,              // serial lane 0
  output logic sample_stream_one_o,               // serial lane 1
  output logic ctrl_ser_o,                        // serial control lane
  output logic fwd_clk_o                          // forwarded clock
);
  import gdc_pkg::*;

  // ==========================================================================
  // sample coding and beat control
  logic                                    phase_q, phase_d;
  logic                                    req_q, req_d;
  logic                                    ack_s1_q, ack_s2_q, ack_l_q;
  logic                                    busy, take;
  logic [GDC_LANES-1:0][GDC_NIB_W-1:0]     coded;
  logic [GDC_LANES-1:0][GDC_SEED_W-1:0]    seed_eff;
  logic [GDC_LANES-1:0][GDC_BYTE_W-1:0]    lane_byte;

  function automatic logic [GDC_NIB_W-1:0] code_nib(
    input logic                 used,
    input logic                 valid,
    input logic [GDC_NIB_W-1:0] nib
  );
    logic [GDC_NIB_W-1:0] r;
    r = nib;
    if (!used) begin
      r = GDC_FILL_NIB;
    end else if (!valid) begin
      r = GDC_INVALID_CODE;
    end else if (nib == GDC_FIVE_VALUE) begin
      r = GDC_FIVE_SUB;
    end
    return r;
  endfunction : code_nib

  function automatic logic [GDC_SEED_W-1:0] safe_seed(
    input logic [GDC_SEED_W-1:0] s
  );
    return (s == GDC_SEED_ZERO) ? GDC_SEED_SAFE : s;
  endfunction : safe_seed

  // lane one never shares lane zero's seed
  always_comb begin
    seed_eff[0] = safe_seed(seed_zero_i);
    seed_eff[1] = safe_seed(seed_one_i);
    if (seed_eff[1] == seed_eff[0]) begin
      seed_eff[1] = safe_seed(~seed_eff[0]);
    end
  end

  assign busy       = req_q ^ ack_s2_q;
  assign in_ready_o = ce_i & ~(phase_q & busy);
  assign take       = in_valid_i & in_ready_o;

  generate
    for (genvar l = 0; l < GDC_LANES; l++) begin : g_lane
      assign coded[l] = code_nib(sample_used_i[l], sample_valid_i[l],
                                 sample_nib_i[l]);
      gdc_chop u_chop (
        .clk_i    (ref_clk_i),
        .rst_n_i  (reset_n_i),
        .ce_i     (ce_i),
        .step_i   (take),
        .phase_i  (phase_q),
        .preset_i (tick_i & ~phase_q),
        .seed_i   (seed_eff[l]),
        .nib_i    (coded[l]),
        .byte_o   (lane_byte[l])
      );
    end
  endgenerate

  // ==========================================================================
  // control word build and seed insertion
  logic [GDC_BYTE_W-1:0]    ctrl_pend_q, ctrl_pend_d;
  logic [GDC_BYTE_W-1:0]    ctrl_word_q, ctrl_word_d;
  logic [GDC_SEED_BITS-1:0] seed_sr_q, seed_sr_d;
  logic [GDC_SEED_BITS-1:0] seed_left_q, seed_left_d;
  logic [GDC_BYTE_W-1:0]    cbits;
  logic                     tc_bit, pm_bit;

  always_comb begin
    seed_sr_d   = seed_sr_q;
    seed_left_d = seed_left_q;
    tc_bit      = timecode_bit_i;
    if (take && !phase_q) begin
      if (tick_i) begin
        seed_sr_d   = {seed_eff[0], seed_eff[1]};
        seed_left_d = '1;
      end else if (seed_left_q[GDC_SEED_BITS-1]) begin
        tc_bit      = seed_sr_q[GDC_SEED_BITS-1];
        seed_sr_d   = {seed_sr_q[GDC_SEED_BITS-2:0], 1'b0};
        seed_left_d = {seed_left_q[GDC_SEED_BITS-2:0], 1'b0};
      end
    end
  end

  always_comb begin
    pm_bit = (phase_model_wafer_i == wafer_id_i) ? phase_model_stream_i
                                                 : GDC_PREAMBLE_IDLE;
    cbits                  = '0;
    cbits[GDC_CB_TIMECODE] = tc_bit;
    cbits[GDC_CB_PHASE_MD] = pm_bit;
    cbits[GDC_CB_PHASE_ER] = phase_error_stream_i;
    cbits[GDC_CB_DUMP]     = dump_trigger_stream_i;
    cbits[GDC_CB_COMMAND]  = command_bit_i;
    cbits[GDC_CB_STATUS]   = status_bit_i;
    cbits[GDC_CB_NPREAMB]  = ~GDC_PREAMBLE_IDLE;
    cbits[GDC_CB_MARK]     = 1'b1;
    phase_d     = phase_q;
    req_d       = req_q;
    ctrl_pend_d = ctrl_pend_q;
    ctrl_word_d = ctrl_word_q;
    if (take) begin
      phase_d = ~phase_q;
      if (!phase_q) begin
        ctrl_pend_d = cbits;
      end else begin
        ctrl_word_d = ctrl_pend_q;
        req_d       = ~req_q;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_q     <= 1'b0;
      req_q       <= 1'b0;
      ctrl_pend_q <= GDC_IDLE_CTRL;
      ctrl_word_q <= GDC_IDLE_CTRL;
      seed_sr_q   <= '0;
      seed_left_q <= '0;
      ack_s1_q    <= 1'b0;
      ack_s2_q    <= 1'b0;
    end else if (ce_i) begin
      phase_q     <= phase_d;
      req_q       <= req_d;
      ctrl_pend_q <= ctrl_pend_d;
      ctrl_word_q <= ctrl_word_d;
      seed_sr_q   <= seed_sr_d;
      seed_left_q <= seed_left_d;
      ack_s1_q    <= ack_l_q;
      ack_s2_q    <= ack_s1_q;
    end
  end

  // ==========================================================================
  // dump trigger and recirculation counter
  logic [RECIRC_W-1:0] recirc_q, recirc_d;
  logic                dump_q, dump_d, src_match;

  always_comb begin
    src_match = (dump_source_i == source_identifier_i) ||
                (&dump_source_i);
    recirc_d  = recirc_q;
    dump_d    = 1'b0;
    if (block_strobe_i) begin
      recirc_d = recirc_q + 1'b1;
    end
    if (dump_strobe_i && src_match) begin
      if (dump_cmd_i == GDC_CMD_RECIRC_RESET) begin
        recirc_d = start_block_i;
      end else begin
        dump_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      recirc_q <= '0;
      dump_q   <= 1'b0;
    end else if (ce_i) begin
      recirc_q <= recirc_d;
      dump_q   <= dump_d;
    end
  end

  assign recirc_count_o = recirc_q;
  assign dump_action_o  = dump_q;

  // ==========================================================================
  // link domain: reset release, crossing, serialiser
  logic                    lrst_s1_q, lrst_n_q;
  logic                    req_s1_q, req_s2_q, ce_s1_q, ce_s2_q;
  logic                    ack_l_d;
  logic [GDC_BITCNT_W-1:0] bit_q, bit_d;
  logic [GDC_BYTE_W-1:0]   sh0_q, sh0_d, sh1_q, sh1_d, shc_q, shc_d;

  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lrst_s1_q <= 1'b0;
      lrst_n_q  <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrst_n_q  <= lrst_s1_q;
    end
  end

  always_comb begin
    bit_d   = bit_q + 1'b1;
    ack_l_d = ack_l_q;
    sh0_d   = {1'b0, sh0_q[GDC_BYTE_W-1:1]};
    sh1_d   = {1'b0, sh1_q[GDC_BYTE_W-1:1]};
    shc_d   = {1'b0, shc_q[GDC_BYTE_W-1:1]};
    if (bit_q == GDC_LAST_BIT) begin
      if (req_s2_q != ack_l_q) begin
        sh0_d   = lane_byte[0];
        sh1_d   = lane_byte[1];
        shc_d   = ctrl_word_q;
        ack_l_d = req_s2_q;
      end else begin
        sh0_d = GDC_IDLE_DATA;
        sh1_d = GDC_IDLE_DATA;
        shc_d = GDC_IDLE_CTRL;
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ce_s1_q  <= 1'b0;
      ce_s2_q  <= 1'b0;
      ack_l_q  <= 1'b0;
      bit_q    <= '0;
      sh0_q    <= GDC_IDLE_DATA;
      sh1_q    <= GDC_IDLE_DATA;
      shc_q    <= GDC_IDLE_CTRL;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      ce_s1_q  <= ce_i;
      ce_s2_q  <= ce_s1_q;
      if (ce_s2_q) begin
        ack_l_q <= ack_l_d;
        bit_q   <= bit_d;
        sh0_q   <= sh0_d;
        sh1_q   <= sh1_d;
        shc_q   <= shc_d;
      end
    end
  end

  // lanes and clock all leave from link flops
  assign sample_stream_zero_o = sh0_q[0];
  assign sample_stream_one_o  = sh1_q[0];
  assign ctrl_ser_o           = shc_q[0];
  assign fwd_clk_o            = bit_q[GDC_FCLK_BIT];

endmodule : gdc_tx

// ==== verification/gdc_tx_props.sv ====
`timescale 1ns/1ps
module gdc_tx_props #(
  parameter int WAFER_W  = 4,
  parameter int SOURCE_W = 6,
  parameter int RECIRC_W = 8
) (
  input wire logic                ref_clk_i,           // clock
  input wire logic                reset_n_i,           // reset
  input wire logic                link_clk_i,          // bit clock
  input wire logic                ce_i,                // enable
  input wire logic                in_valid_i,          // beat offered
  input wire logic                in_ready_o,          // beat taken
  input wire logic                dump_strobe_i,       // dump frame
  input wire logic [2:0]          dump_cmd_i,          // command
  input wire logic [SOURCE_W-1:0] dump_source_i,       // frame id
  input wire logic [SOURCE_W-1:0] source_identifier_i, // own id
  input wire logic                block_strobe_i,      // block done
  input wire logic [RECIRC_W-1:0] start_block_i,       // start block
  input wire logic [RECIRC_W-1:0] recirc_count_o,      // counter
  input wire logic                dump_action_o,       // dump pulse
  input wire logic                ctrl_ser_o,          // control lane
  input wire logic                fwd_clk_o            // forwarded clock
);
  import gdc_pkg::*;
  logic phase_q, phase_d, hit, rr;
  assign hit = ce_i && dump_strobe_i &&
               (dump_source_i == source_identifier_i || &dump_source_i);
  assign rr  = hit && dump_cmd_i == GDC_CMD_RECIRC_RESET;
  // ====================
  // beat phase tracker
  always_comb phase_d = phase_q ^ (in_valid_i && in_ready_o);
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) phase_q <= 1'b0;
    else            phase_q <= phase_d;
  end
  // ====================
  // properties
  recirc_reset_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    rr |=> recirc_count_o == $past(start_block_i) && !dump_action_o)
    else $error("recirc counter not reloaded");
  dump_pulse_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    hit && !rr |=> dump_action_o)
    else $error("dump pulse missing");
  no_dump_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    !(hit && !rr) |=> !dump_action_o)
    else $error("unexpected dump pulse");
  block_count_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && block_strobe_i && !rr |=>
      recirc_count_o == $past(recirc_count_o) + RECIRC_W'(1))
    else $error("recirc counter did not step");
  count_hold_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && !block_strobe_i && !rr |=> $stable(recirc_count_o))
    else $error("recirc counter moved");
  w0_ready_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && !phase_q |-> in_ready_o)
    else $error("even beat refused");
  ready_back_a: assert property (
    @(posedge ref_clk_i) disable iff (!reset_n_i)
    ce_i && !in_ready_o |-> ##[1:60] in_ready_o)
    else $error("serialiser never freed");
  fwd_period_a: assert property (
    @(posedge link_clk_i) disable iff (!reset_n_i)
    $rose(fwd_clk_o) |-> fwd_clk_o [*4] ##1 !fwd_clk_o [*4])
    else $error("forwarded clock period wrong");
  ctrl_mark_a: assert property (
    @(posedge link_clk_i) disable iff (!reset_n_i)
    $fell(fwd_clk_o) |-> ##6 ctrl_ser_o [*2])
    else $error("control marker bits low");
  cover property (@(posedge ref_clk_i) rr);
  cover property (@(posedge ref_clk_i) hit && !rr && &dump_source_i);
  cover property (@(posedge ref_clk_i) phase_q && !in_ready_o);
endmodule : gdc_tx_props

bind gdc_tx gdc_tx_props #(
  .WAFER_W(WAFER_W), .SOURCE_W(SOURCE_W), .RECIRC_W(RECIRC_W)
) i_props (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk_i),
  .ce_i(ce_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
  .dump_strobe_i(dump_strobe_i), .dump_cmd_i(dump_cmd_i),
  .dump_source_i(dump_source_i), .source_identifier_i(source_identifier_i),
  .block_strobe_i(block_strobe_i), .start_block_i(start_block_i),
  .recirc_count_o(recirc_count_o), .dump_action_o(dump_action_o),
  .ctrl_ser_o(ctrl_ser_o), .fwd_clk_o(fwd_clk_o)
);

// ==== verification/gdc_rx_model.sv ====
`timescale 1ns/1ps
module gdc_rx_model (
  input  wire logic       link_clk_i, // bit clock
  input  wire logic       lane0_i,    // sample lane 0
  input  wire logic       lane1_i,    // sample lane 1
  input  wire logic       ctrl_i,     // control lane
  input  wire logic       fwd_clk_i,  // forwarded clock
  output logic            word_stb_o, // word done
  output logic      [7:0] data0_o,    // lane 0 byte
  output logic      [7:0] data1_o,    // lane 1 byte
  output logic      [7:0] ctrl_o      // control byte
);
  logic [2:0] bit_q  = 3'h0;
  logic       fwd_q  = 1'b0;
  logic       lock_q = 1'b0;
  logic [7:0] s0, s1, sc;
  // word start is the sample where the forwarded clock has fallen
  always @(posedge link_clk_i) begin
    bit_q = (fwd_q && !fwd_clk_i) ? 3'h0 : bit_q + 3'h1;
    lock_q = lock_q | (fwd_q && !fwd_clk_i);
    fwd_q = fwd_clk_i;
    s0 = {lane0_i, s0[7:1]};
    s1 = {lane1_i, s1[7:1]};
    sc = {ctrl_i, sc[7:1]};
    word_stb_o <= lock_q && bit_q == 3'h7;
    data0_o <= s0;
    data1_o <= s1;
    ctrl_o <= sc;
  end
endmodule : gdc_rx_model

// ==== verification/gdc_tx_tb_top.sv ====
`timescale 1ns/1ps
module gdc_tx_tb_top;
  import gdc_pkg::*;
  localparam logic [23:0] IDLE_W = {GDC_IDLE_CTRL, GDC_IDLE_DATA,
                                    GDC_IDLE_DATA};
  logic            ref_clk_i = 0, link_clk_i = 0, reset_n_i = 0;
  logic            in_valid_i = 0, tick = 0, ds = 0, bs = 0, rdy, dact;
  logic            tc = 0, pm = 0, pe = 0, dt = 0, cm = 0, st = 0;
  logic [1:0][3:0] nib = '0;
  logic [1:0]      used = '0, valid = '0;
  logic [3:0]      pmw = '0, waf = 4'h3;
  logic [5:0]      own = 6'h15, src = '0;
  logic [2:0]      cmd = '0;
  logic [7:0]      sd0 = '0, sd1 = '0, sb = '0, rc, w0, w1, wc;
  logic [7:0]      e0, e1, p0, p1, cnt = '0;
  logic            l0, l1, lc, fc, stb;
  logic [31:0]     rng_q = 32'hAB96247A;
  logic [23:0]     exp_q[$];
  int              fails = 0, compares = 0, sidx = 17;

  always #12.5 ref_clk_i = ~ref_clk_i;
  always #16 link_clk_i = ~link_clk_i;

  gdc_tx i_dut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .link_clk_i(link_clk_i), .in_valid_i(in_valid_i), .in_ready_o(rdy),
    .sample_nib_i(nib), .sample_used_i(used), .sample_valid_i(valid),
    .tick_i(tick), .timecode_bit_i(tc), .phase_model_stream_i(pm),
    .phase_model_wafer_i(pmw), .phase_error_stream_i(pe),
    .dump_trigger_stream_i(dt), .command_bit_i(cm), .status_bit_i(st),
    .seed_zero_i(sd0), .seed_one_i(sd1), .wafer_id_i(waf),
    .source_identifier_i(own), .dump_strobe_i(ds), .dump_cmd_i(cmd),
    .dump_source_i(src), .block_strobe_i(bs), .start_block_i(sb),
    .recirc_count_o(rc), .dump_action_o(dact), .sample_stream_zero_o(l0),
    .sample_stream_one_o(l1), .ctrl_ser_o(lc), .fwd_clk_o(fc)
  );
  gdc_rx_model i_rx (
    .link_clk_i(link_clk_i), .lane0_i(l0), .lane1_i(l1), .ctrl_i(lc),
    .fwd_clk_i(fc), .word_stb_o(stb), .data0_o(w0), .data1_o(w1), .ctrl_o(wc)
  );
  // ====================
  // helpers
  function automatic logic [31:0] xs();
    rng_q = rng_q ^ (rng_q << 13);
    rng_q = rng_q ^ (rng_q >> 17);
    rng_q = rng_q ^ (rng_q << 5);
    return rng_q;
  endfunction : xs
  function automatic logic [3:0] enc(logic u, logic v, logic [3:0] n);
    if (!u) return GDC_FILL_NIB;
    if (!v) return GDC_INVALID_CODE;
    return (n == GDC_FIVE_VALUE) ? GDC_FIVE_SUB : n;
  endfunction : enc
  function automatic logic [7:0] nxt(logic [7:0] p);
    return {p[6:0], ^(p & GDC_PRN_TAPS)};
  endfunction : nxt
  function automatic logic [7:0] fix0(logic [7:0] s);
    return (s == GDC_SEED_ZERO) ? GDC_SEED_SAFE : s;
  endfunction : fix0
  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte
  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic tally_and_finish();
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // ====================
  // beat traffic
  task automatic take();
    int k;
    in_valid_i <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(negedge ref_clk_i);
      if (rdy === 1'b1) break;
    end
    if (k == 100) begin
      fails++;
      tally_and_finish();
    end
    @(posedge ref_clk_i);
  endtask : take
  // md 1: slots unused, 2: invalid samples, 3: genuine fives
  task automatic pair(input logic tk, input int md);
    logic [31:0] r;
    logic [1:0][3:0] n;
    logic [1:0] u, v;
    logic [7:0] d0, d1, cw;
    logic [15:0] sbits;
    for (int w = 0; w < 2; w++) begin
      r = xs();
      n = (md == 3) ? 8'h55 : r[7:0];
      u = (md == 1) ? 2'b00 : {r[8] | r[9], r[10] | r[11]};
      v = (md == 2) ? 2'b00 : {r[12] | r[13], r[14] | r[15]};
      nib <= n;
      used <= u;
      valid <= v;
      tick <= tk && w == 0;
      if (tk && w == 0) begin
        p0 = e0;
        p1 = e1;
        sidx = 0;
      end
      d0[w*4 +: 4] = enc(u[0], v[0], n[0]) ^ p0[3:0];
      d1[w*4 +: 4] = enc(u[1], v[1], n[1]) ^ p1[3:0];
      p0 = nxt(p0);
      p1 = nxt(p1);
      if (w == 0) begin
        {st, cm, dt, pe, pm, tc} <= r[21:16];
        pmw <= r[22] ? waf : r[26:23];
        sbits = {e0, e1};
        cw = {2'b11, r[21:18], r[17] && (r[22] || r[26:23] == waf),
              (sidx > 0 && sidx < 17) ? sbits[16 - sidx] : r[16]};
        sidx++;
      end
      else exp_q.push_back({cw, d1, d0});
      take();
    end
  endtask : pair
  task automatic burst(input logic [7:0] a, input logic [7:0] b, input int n);
    sd0 <= a;
    sd1 <= b;
    e0 = fix0(a);
    e1 = (fix0(b) == e0) ? fix0(~e0) : fix0(b);
    @(posedge ref_clk_i);
    for (int j = 0; j < n; j++) pair(j % 20 == 0, j % 10);
    in_valid_i <= 1'b0;
    for (int k = 0; k < 400 && exp_q.size() > 0; k++) @(posedge ref_clk_i);
    if (exp_q.size() > 0) fails++;
  endtask : burst
  // ====================
  // word checking at the far end
  always @(posedge link_clk_i) begin
    logic [23:0] e;
    if (stb === 1'b1) begin
      if (exp_q.size() > 0 && ({wc, w1, w0} !== IDLE_W ||
          exp_q[0] === IDLE_W)) begin
        e = exp_q.pop_front();
        chk_byte("lane0", e[7:0], w0);
        chk_byte("lane1", e[15:8], w1);
        chk_byte("ctrl", e[23:16], wc);
      end
      else begin
        chk_byte("idle0", IDLE_W[7:0], w0);
        chk_byte("idle1", IDLE_W[15:8], w1);
        chk_byte("idlec", IDLE_W[23:16], wc);
      end
    end
  end
  // ====================
  // main sequence
  initial begin
    logic [31:0] r;
    logic [2:0]  c;
    logic [5:0]  s;
    logic        h;
    repeat (10) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    burst(8'h00, 8'h00, 12);
    r = xs();
    burst(r[7:0], r[15:8], 30);
    for (int i = 0; i < 40; i++) begin
      r = xs();
      c = (i < 8) ? 3'(i) : r[2:0];
      s = (i % 3 == 0) ? 6'h3F : (i % 3 == 1) ? own : r[8:3];
      h = (s == own) || (&s);
      ds <= 1'b1;
      cmd <= c;
      src <= s;
      bs <= r[9];
      sb <= r[17:10];
      if (h && c == GDC_CMD_RECIRC_RESET) cnt = r[17:10];
      else if (r[9]) cnt = cnt + 8'h01;
      @(posedge ref_clk_i);
      ds <= 1'b0;
      bs <= 1'b0;
      @(negedge ref_clk_i);
      chk_byte("recirc", cnt, rc);
      chk_bit("dump", h && c != GDC_CMD_RECIRC_RESET, dact);
      @(posedge ref_clk_i);
    end
    tally_and_finish();
  end
endmodule : gdc_tx_tb_top
